// ==== hw/char_fifo.sv ====
// synchronous character fifo with flush
`timescale 1ns/1ns
module char_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic flush,
  input wire logic push,
  input wire logic [WIDTH-1:0] push_data,
  input wire logic pop,
  output logic [WIDTH-1:0] pop_data,
  output logic empty,
  output logic full,
  output logic [$clog2(DEPTH+1)-1:0] count
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic do_push;
  logic do_pop;

  assign empty = (count == '0);
  assign full = (count == CW'(DEPTH));
  assign do_push = push & ~full;
  assign do_pop = pop & ~empty;
  assign pop_data = mem[rd_ptr];

  always_ff @(posedge ref_clk)
  begin
    if (do_push)
    begin
      mem[wr_ptr] <= push_data;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n || flush)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      if (do_push)
      begin
        wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : PW'(wr_ptr + 1'b1);
      end
      if (do_pop)
      begin
        rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : PW'(rd_ptr + 1'b1);
      end
      count <= CW'(count + CW'(do_push) - CW'(do_pop));
    end
  end
endmodule

// ==== hw/uart_shadow_data_port.sv ====
// shadow data port of a uart: avalon slave, fifos, serial and infrared lines
// ==========================================================
// Contract
// - sixteen aliased word locations all reach the same rx and tx data path
// - fifos off, shadow read returns last byte received on serial or infrared input
// - received data valid only while the data ready flag is set
// - fifos off, new character overwrites unread byte and flags overrun
// - fifos on, shadow read returns head of receive fifo
// - full receive fifo keeps contents, drops new character, flags overrun
// - written byte is sent on serial output, or active-low infrared output
// - fifos off, write clears empty flag; later writes overwrite held byte
// - fifos on, accepts fifo depth writes, default sixteen, before full
// - transmit data written while tx fifo full is discarded
`timescale 1ns/1ns
module uart_shadow_data_port #(
  parameter int CYCLES_PER_BIT = uart_shadow_pkg::BIT_CYCLES,
  parameter int DEPTH = uart_shadow_pkg::FIFO_DEPTH
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [31:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic sin,
  output logic sout,
  input wire logic sir_in,
  output logic sir_out_n,
  output logic irq
);
  import uart_shadow_pkg::*;
  localparam int CNT_W = $clog2(CYCLES_PER_BIT + 1);
  localparam int CW = $clog2(DEPTH + 1);
  localparam int IR_PULSE = (CYCLES_PER_BIT * 3) / 16;

  // ==========================================================
  // bus slave
  logic acc_ack;
  logic rd_done;
  logic wr_done;
  logic hit_shadow;
  logic rd_shadow;
  logic rd_had_data;
  logic [31:0] read_mux;
  logic fifo_en;
  logic ir_mode;
  logic [IRQ_BITS-1:0] irq_status;
  logic [IRQ_BITS-1:0] irq_mask;
  logic overrun;
  logic data_ready;
  logic thr_empty;
  logic [DATA_BITS-1:0] rx_head;

  assign hit_shadow = (avs_address >= SHADOW_BASE_ADDR) && (avs_address < SHADOW_END_ADDR)
    && (avs_address[1:0] == 2'h0);
  assign avs_waitrequest = (avs_read | avs_write) & ~acc_ack;
  assign rd_done = avs_read & acc_ack;
  assign wr_done = avs_write & acc_ack;

  always_comb
  begin
    read_mux = 32'h0;
    if (hit_shadow)
    begin
      read_mux[DATA_BITS-1:0] = data_ready ? rx_head : SHADOW_RESET;
    end
    else if (avs_address == LINE_STATUS_ADDR)
    begin
      read_mux[LSR_DATA_READY_BIT] = data_ready;
      read_mux[LSR_OVERRUN_BIT] = overrun;
      read_mux[LSR_THR_EMPTY_BIT] = thr_empty;
    end
    else if (avs_address == FIFO_CONTROL_ADDR)
    begin
      read_mux[FCR_FIFO_EN_BIT] = fifo_en;
    end
    else if (avs_address == MODE_CONTROL_ADDR)
    begin
      read_mux[MODE_IR_BIT] = ir_mode;
    end
    else if (avs_address == IRQ_STATUS_ADDR)
    begin
      read_mux[IRQ_BITS-1:0] = irq_status;
    end
    else if (avs_address == IRQ_MASK_ADDR)
    begin
      read_mux[IRQ_BITS-1:0] = irq_mask;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      acc_ack <= 1'b0;
      avs_readdata <= 32'h0;
      rd_shadow <= 1'b0;
      rd_had_data <= 1'b0;
    end
    else
    begin
      acc_ack <= (avs_read | avs_write) & ~acc_ack;
      if (avs_read && !acc_ack)
      begin
        avs_readdata <= read_mux;
        rd_shadow <= hit_shadow;
        rd_had_data <= hit_shadow & data_ready;
      end
    end
  end

  // ==========================================================
  // control registers
  logic fifo_en_q;
  logic flush;
  logic ctrl_byte;

  assign ctrl_byte = wr_done & avs_byteenable[0];
  assign flush = fifo_en != fifo_en_q;

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      fifo_en <= FIFO_EN_RESET;
      fifo_en_q <= FIFO_EN_RESET;
      ir_mode <= IR_MODE_RESET;
      irq_mask <= IRQ_MASK_RESET;
    end
    else
    begin
      fifo_en_q <= fifo_en;
      if (ctrl_byte && avs_address == FIFO_CONTROL_ADDR)
      begin
        fifo_en <= avs_writedata[FCR_FIFO_EN_BIT];
      end
      if (ctrl_byte && avs_address == MODE_CONTROL_ADDR)
      begin
        ir_mode <= avs_writedata[MODE_IR_BIT];
      end
      if (ctrl_byte && avs_address == IRQ_MASK_ADDR)
      begin
        irq_mask <= avs_writedata[IRQ_BITS-1:0];
      end
    end
  end

  // ==========================================================
  // line input synchronisers and infrared stretch
  logic [2:0] sin_sync;
  logic [2:0] sir_sync;
  logic sin_clean;
  logic sir_clean;
  logic [CNT_W-1:0] ir_stretch;
  logic rx_line;

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      sin_sync <= 3'h7;
      sir_sync <= 3'h0;
      sin_clean <= 1'b1;
      sir_clean <= 1'b0;
      ir_stretch <= '0;
    end
    else
    begin
      sin_sync <= {sin_sync[1:0], sin};
      sir_sync <= {sir_sync[1:0], sir_in};
      if (sin_sync[1] == sin_sync[2])
      begin
        sin_clean <= sin_sync[2];
      end
      if (sir_sync[1] == sir_sync[2])
      begin
        sir_clean <= sir_sync[2];
      end
      if (sir_clean)
      begin
        ir_stretch <= CNT_W'(CYCLES_PER_BIT);
      end
      else if (ir_stretch != '0)
      begin
        ir_stretch <= CNT_W'(ir_stretch - 1'b1);
      end
    end
  end

  assign rx_line = ir_mode ? (ir_stretch == '0) : sin_clean;

  // ==========================================================
  // receiver
  rx_state_t rx_state;
  logic [CNT_W-1:0] rx_cnt;
  logic [2:0] rx_bitn;
  logic [DATA_BITS-1:0] rx_shift;
  logic rx_done;

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      rx_state <= RX_IDLE;
      rx_cnt <= '0;
      rx_bitn <= 3'h0;
      rx_shift <= 8'h00;
      rx_done <= 1'b0;
    end
    else
    begin
      rx_done <= 1'b0;
      if (rx_cnt != '0)
      begin
        rx_cnt <= CNT_W'(rx_cnt - 1'b1);
      end
      case (rx_state)
        RX_IDLE:
        begin
          if (!rx_line)
          begin
            rx_state <= RX_START;
            rx_cnt <= CNT_W'(CYCLES_PER_BIT / 2);
          end
        end
        RX_START:
        begin
          if (rx_cnt == '0)
          begin
            rx_state <= rx_line ? RX_IDLE : RX_DATA;
            rx_cnt <= CNT_W'(CYCLES_PER_BIT - 1);
            rx_bitn <= 3'h0;
          end
        end
        RX_DATA:
        begin
          if (rx_cnt == '0)
          begin
            rx_shift <= {rx_line, rx_shift[DATA_BITS-1:1]};
            rx_cnt <= CNT_W'(CYCLES_PER_BIT - 1);
            rx_bitn <= 3'(rx_bitn + 1'b1);
            if (rx_bitn == 3'h7)
            begin
              rx_state <= RX_STOP;
            end
          end
        end
        RX_STOP:
        begin
          if (rx_cnt == '0)
          begin
            rx_done <= 1'b1;
            rx_state <= RX_IDLE;
          end
        end
        default:
        begin
          rx_state <= RX_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // receive holding register and fifo
  logic [DATA_BITS-1:0] rx_hold;
  logic rx_hold_valid;
  logic rx_pop;
  logic rx_empty;
  logic rx_full;
  logic [CW-1:0] rx_count;
  logic [DATA_BITS-1:0] rx_fifo_head;
  logic overrun_event;
  logic rx_accept;

  assign rx_pop = rd_done & rd_shadow & rd_had_data;
  assign overrun_event = rx_done & (fifo_en ? rx_full : rx_hold_valid & ~rx_pop);
  assign rx_accept = rx_done & ~(fifo_en & rx_full);
  assign data_ready = fifo_en ? ~rx_empty : rx_hold_valid;
  assign rx_head = fifo_en ? rx_fifo_head : rx_hold;

  char_fifo #(.WIDTH(DATA_BITS), .DEPTH(DEPTH)) rx_fifo (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .flush(flush),
    .push(rx_done & fifo_en),
    .push_data(rx_shift),
    .pop(rx_pop & fifo_en),
    .pop_data(rx_fifo_head),
    .empty(rx_empty),
    .full(rx_full),
    .count(rx_count)
  );

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n || flush)
    begin
      rx_hold <= SHADOW_RESET;
      rx_hold_valid <= 1'b0;
    end
    else if (rx_done && !fifo_en)
    begin
      rx_hold <= rx_shift;
      rx_hold_valid <= 1'b1;
    end
    else if (rx_pop && !fifo_en)
    begin
      rx_hold_valid <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      overrun <= 1'b0;
    end
    else
    begin
      overrun <= (overrun & ~(rd_done & (avs_address == LINE_STATUS_ADDR)
        & avs_readdata[LSR_OVERRUN_BIT])) | overrun_event;
    end
  end

  // ==========================================================
  // transmit holding register and fifo
  logic [DATA_BITS-1:0] tx_hold;
  logic tx_hold_full;
  logic tx_write;
  logic tx_take;
  logic tx_empty;
  logic tx_full;
  logic [CW-1:0] tx_count;
  logic [DATA_BITS-1:0] tx_fifo_head;
  logic tx_avail;
  tx_state_t tx_state;

  assign tx_write = wr_done & hit_shadow & avs_byteenable[0];
  assign tx_avail = fifo_en ? ~tx_empty : tx_hold_full;
  assign tx_take = (tx_state == TX_IDLE) & tx_avail;
  assign thr_empty = fifo_en ? tx_empty : ~tx_hold_full;

  char_fifo #(.WIDTH(DATA_BITS), .DEPTH(DEPTH)) tx_fifo (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .flush(flush),
    .push(tx_write & fifo_en),
    .push_data(avs_writedata[DATA_BITS-1:0]),
    .pop(tx_take & fifo_en),
    .pop_data(tx_fifo_head),
    .empty(tx_empty),
    .full(tx_full),
    .count(tx_count)
  );

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n || flush)
    begin
      tx_hold <= SHADOW_RESET;
      tx_hold_full <= 1'b0;
    end
    else if (tx_write && !fifo_en)
    begin
      tx_hold <= avs_writedata[DATA_BITS-1:0];
      tx_hold_full <= 1'b1;
    end
    else if (tx_take && !fifo_en)
    begin
      tx_hold_full <= 1'b0;
    end
  end

  // ==========================================================
  // transmitter
  logic [CNT_W-1:0] tx_cnt;
  logic [2:0] tx_bitn;
  logic [DATA_BITS-1:0] tx_shift;
  logic tx_line;

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      tx_state <= TX_IDLE;
      tx_cnt <= '0;
      tx_bitn <= 3'h0;
      tx_shift <= 8'h00;
      tx_line <= 1'b1;
    end
    else
    begin
      if (tx_cnt != '0)
      begin
        tx_cnt <= CNT_W'(tx_cnt - 1'b1);
      end
      case (tx_state)
        TX_IDLE:
        begin
          tx_line <= 1'b1;
          if (tx_avail)
          begin
            tx_shift <= fifo_en ? tx_fifo_head : tx_hold;
            tx_line <= 1'b0;
            tx_cnt <= CNT_W'(CYCLES_PER_BIT - 1);
            tx_state <= TX_START;
          end
        end
        TX_START:
        begin
          if (tx_cnt == '0)
          begin
            tx_line <= tx_shift[0];
            tx_shift <= {1'b0, tx_shift[DATA_BITS-1:1]};
            tx_cnt <= CNT_W'(CYCLES_PER_BIT - 1);
            tx_bitn <= 3'h0;
            tx_state <= TX_DATA;
          end
        end
        TX_DATA:
        begin
          if (tx_cnt == '0)
          begin
            tx_cnt <= CNT_W'(CYCLES_PER_BIT - 1);
            tx_bitn <= 3'(tx_bitn + 1'b1);
            if (tx_bitn == 3'h7)
            begin
              tx_line <= 1'b1;
              tx_state <= TX_STOP;
            end
            else
            begin
              tx_line <= tx_shift[0];
              tx_shift <= {1'b0, tx_shift[DATA_BITS-1:1]};
            end
          end
        end
        TX_STOP:
        begin
          if (tx_cnt == '0)
          begin
            tx_state <= TX_IDLE;
          end
        end
        default:
        begin
          tx_state <= TX_IDLE;
        end
      endcase
    end
  end

  // infrared pulse in the first part of each zero bit
  assign sout = ir_mode | tx_line;
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      sir_out_n <= 1'b1;
    end
    else
    begin
      sir_out_n <= ~(ir_mode & (tx_state != TX_IDLE) & ~tx_line
        & (tx_cnt > CNT_W'(CYCLES_PER_BIT - 1 - IR_PULSE)));
    end
  end

  // ==========================================================
  // interrupts
  logic thr_empty_q;
  logic [IRQ_BITS-1:0] irq_events;

  assign irq_events = {thr_empty & ~thr_empty_q, overrun_event, rx_accept};
  assign irq = |(irq_status & irq_mask);

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      thr_empty_q <= 1'b1;
      irq_status <= '0;
    end
    else
    begin
      thr_empty_q <= thr_empty;
      irq_status <= (irq_status & ~((rd_done && avs_address == IRQ_STATUS_ADDR)
        ? avs_readdata[IRQ_BITS-1:0] : '0)) | irq_events;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  a_shadow_upper_zero: assert property (rd_done && rd_shadow |-> avs_readdata[31:8] == 24'h0)
    else $error("shadow upper bits not zero");
  a_ready_gates_data: assert property (rd_done && rd_shadow && !rd_had_data
    |-> avs_readdata[7:0] == 8'h00)
    else $error("shadow data shown without data ready");
  a_rx_lands_hold: assert property (rx_done && !fifo_en && !flush
    |=> rx_hold == $past(rx_shift) && rx_hold_valid)
    else $error("received byte not held");
  a_overrun_nofifo: assert property (rx_done && !fifo_en && rx_hold_valid && !rx_pop
    |=> overrun)
    else $error("overwrite without overrun");
  a_rx_fifo_keep: assert property (rx_done && fifo_en && rx_full && !rx_pop && !flush
    |=> overrun && rx_count == $past(rx_count))
    else $error("full rx fifo changed on arrival");
  a_fifo_head_read: assert property (rd_done && rd_shadow && rd_had_data && fifo_en && !flush
    ##0 $past(avs_read) |=> rx_count == $past(rx_count) - CW'(1)
    + CW'($past(rx_done) && !$past(rx_full)))
    else $error("fifo read did not pop head");
  a_tx_holding_empty_flag_clear: assert property (tx_write && !fifo_en && !flush |=> !thr_empty)
    else $error("write left holding empty flag set");
  a_tx_fifo_fill: assert property (tx_write && fifo_en && !tx_full && !tx_take && !flush
    |=> tx_count == $past(tx_count) + CW'(1))
    else $error("tx fifo did not accept write");
  a_tx_full_drop: assert property (tx_write && fifo_en && tx_full && !tx_take && !flush
    |=> tx_full && tx_count == CW'(DEPTH))
    else $error("write to full tx fifo queued");
  a_tx_start_bit: assert property (tx_take && !ir_mode ##1 !ir_mode
    |-> !sout ##1 !sout)
    else $error("start bit missing on serial output");
endmodule

// ==== hw/uart_shadow_pkg.sv ====
// constants and types of the shadow data port
package uart_shadow_pkg;
  // ==========================================================
  // register map
  localparam logic [31:0] SHADOW_10_ADDR = 32'h50001158;
  localparam logic [31:0] SHADOW_11_ADDR = 32'h5000115C;
  localparam int SHADOW_10_INDEX = 10;
  localparam int SHADOW_COUNT = 16;
  localparam logic [31:0] SHADOW_BASE_ADDR = SHADOW_10_ADDR - 32'(SHADOW_10_INDEX * 4);
  localparam logic [31:0] SHADOW_END_ADDR = SHADOW_BASE_ADDR + 32'(SHADOW_COUNT * 4);
  localparam logic [31:0] LINE_STATUS_ADDR = 32'h50001200;
  localparam logic [31:0] FIFO_CONTROL_ADDR = 32'h50001204;
  localparam logic [31:0] MODE_CONTROL_ADDR = 32'h50001208;
  localparam logic [31:0] IRQ_STATUS_ADDR = 32'h5000120C;
  localparam logic [31:0] IRQ_MASK_ADDR = 32'h50001210;
  // ==========================================================
  // field positions
  localparam int LSR_DATA_READY_BIT = 0;
  localparam int LSR_OVERRUN_BIT = 1;
  localparam int LSR_THR_EMPTY_BIT = 5;
  localparam int FCR_FIFO_EN_BIT = 0;
  localparam int MODE_IR_BIT = 0;
  localparam int IRQ_RX_BIT = 0;
  localparam int IRQ_OVERRUN_BIT = 1;
  localparam int IRQ_TX_HOLDING_EMPTY_FLAG_BIT = 2;
  localparam int IRQ_BITS = 3;
  localparam int DATA_BITS = 8;
  // ==========================================================
  // reset values
  localparam logic [DATA_BITS-1:0] SHADOW_RESET = 8'h00;
  localparam logic FIFO_EN_RESET = 1'b0;
  localparam logic IR_MODE_RESET = 1'b0;
  localparam logic [IRQ_BITS-1:0] IRQ_MASK_RESET = 3'h0;
  // ==========================================================
  // timing
  localparam int CLOCK_HZ = 10_000_000;
  localparam int BIT_RATE_BPS = 115200;
  localparam int BIT_CYCLES = CLOCK_HZ / BIT_RATE_BPS;
  localparam int FIFO_DEPTH = 16;
  // ==========================================================
  // state machines
  typedef enum logic [3:0] {
    RX_IDLE = 4'h1,
    RX_START = 4'h2,
    RX_DATA = 4'h4,
    RX_STOP = 4'h8
  } rx_state_t;
  typedef enum logic [3:0] {
    TX_IDLE = 4'h1,
    TX_START = 4'h2,
    TX_DATA = 4'h4,
    TX_STOP = 4'h8
  } tx_state_t;
endpackage

// ==== test/serial_peer.sv ====
// remote serial peer: sends and takes 8n1 frames, plain or infrared
`timescale 1ns/1ns
module serial_peer #(
  parameter int CYCLES_PER_BIT = 8
) (
  input wire logic ref_clk,
  input wire logic sout,
  input wire logic sir_out_n,
  output logic sin,
  output logic sir_in
);
  localparam int B = CYCLES_PER_BIT;
  initial
  begin
    sin = 1'b1;
    sir_in = 1'b0;
  end
  // ==========================================================
  // send one frame, lsb first; infrared marks a zero by a short pulse
  task automatic send(input logic [7:0] b, input logic ir);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    @(posedge ref_clk);
    for (int i = 0; i < 10; i++)
    begin
      if (ir)
        sir_in <= !f[i];
      else
        sin <= f[i];
      repeat (2) @(posedge ref_clk);
      sir_in <= 1'b0;
      repeat (B - 2) @(posedge ref_clk);
    end
    // idle gap covers the receiver's input delay
    repeat (B) @(posedge ref_clk);
  endtask
  // ==========================================================
  // take one frame within lim cycles; ok low if none came
  task automatic recv(input logic ir, input int lim, output logic [7:0] b, output logic ok);
    int n;
    logic z;
    n = 0;
    ok = 1'b0;
    b = 8'h00;
    while (n < lim && (ir ? sir_out_n : sout) !== 1'b0)
    begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= lim)
      return;
    repeat (B) @(posedge ref_clk);
    for (int i = 0; i < 8; i++)
    begin
      z = 1'b1;
      for (int k = 0; k < B; k++)
      begin
        if (ir && sir_out_n === 1'b0)
          z = 1'b0;
        if (!ir && k == B / 2)
          z = sout;
        @(posedge ref_clk);
      end
      b[i] = z;
    end
    ok = 1'b1;
  endtask
endmodule

// ==== test/uart_shadow_data_port_bench.sv ====
// testbench of the shadow data port
`timescale 1ns/1ns
module uart_shadow_data_port_bench;
  import uart_shadow_pkg::*;
  localparam int B = 8;
  localparam int D = 4;
  logic ref_clk, rst_n, avs_read, avs_write, sin, sir_in;
  logic avs_waitrequest, sout, sir_out_n, irq;
  logic [31:0] avs_address, avs_writedata, avs_readdata, q;
  logic [3:0] avs_byteenable;
  int err_count, checks_done;
  uart_shadow_data_port #(.CYCLES_PER_BIT(B), .DEPTH(D)) i_uart_shadow_data_port (
    .ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .sin(sin),
    .sout(sout), .sir_in(sir_in), .sir_out_n(sir_out_n), .irq(irq));
  serial_peer #(.CYCLES_PER_BIT(B)) i_serial_peer (
    .ref_clk(ref_clk), .sout(sout), .sir_out_n(sir_out_n), .sin(sin), .sir_in(sir_in));
  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // ==========================================================
  // helpers
  function automatic logic [31:0] sh(input int k);
    return SHADOW_BASE_ADDR + 32'(4 * k);
  endfunction
  task automatic report_and_stop;
    $display("errors %0d checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic fail(input string m);
    err_count++;
    $display("FAIL %0t %s", $time, m);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e)
      fail($sformatf("got %h want %h", g, e));
  endtask
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !w;
    avs_write <= w;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 50);
    if (avs_waitrequest !== 1'b0)
    begin
      fail("bus timeout");
      report_and_stop;
    end
    else
    begin
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdc(input logic [31:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  task automatic get(input logic ir, input logic [7:0] e);
    logic [7:0] b;
    logic ok;
    i_serial_peer.recv(ir, 30 * B, b, ok);
    if (ok !== 1'b1)
    begin
      fail("no frame");
      report_and_stop;
    end
    else
      chk(32'(b), 32'(e));
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset;
    rdc(sh(10), 32'h0);
    rdc(LINE_STATUS_ADDR, 32'h20);
    rdc(FIFO_CONTROL_ADDR, 32'h0);
    rdc(MODE_CONTROL_ADDR, 32'h0);
    rdc(IRQ_MASK_ADDR, 32'h0);
    rdc(32'h50001300, 32'h0);
  endtask
  task automatic t_rx_off;
    i_serial_peer.send(8'h41, 1'b0);
    rdc(LINE_STATUS_ADDR, 32'h21);
    i_serial_peer.send(8'h42, 1'b0);
    rdc(LINE_STATUS_ADDR, 32'h23);
    rdc(sh(11), 32'h42);
    rdc(sh(11), 32'h0);
  endtask
  task automatic t_rx_fifo;
    wr(FIFO_CONTROL_ADDR, 32'h1);
    for (int i = 0; i <= D; i++)
      i_serial_peer.send(8'(8'h50 + i), 1'b0);
    rdc(LINE_STATUS_ADDR, 32'h23);
    for (int i = 0; i < D; i++)
      rdc(sh(i), 32'h50 + 32'(i));
    rdc(LINE_STATUS_ADDR, 32'h20);
  endtask
  task automatic t_tx_off;
    wr(FIFO_CONTROL_ADDR, 32'h0);
    rdc(LINE_STATUS_ADDR, 32'h20);
    fork
      begin
        get(1'b0, 8'h11);
        get(1'b0, 8'h33);
      end
      begin
        wr(sh(3), 32'hAB11);
        wr(sh(4), 32'h22);
        rdc(LINE_STATUS_ADDR, 32'h0);
        wr(sh(5), 32'h33);
      end
    join
  endtask
  task automatic t_tx_fifo;
    logic [7:0] b;
    logic ok;
    wr(FIFO_CONTROL_ADDR, 32'h1);
    fork
      begin
        for (int i = 0; i <= D; i++)
          get(1'b0, 8'(8'h60 + i));
        i_serial_peer.recv(1'b0, 20 * B, b, ok);
        chk(32'(ok), 32'h0);
      end
      for (int i = 0; i <= D + 1; i++)
        wr(sh(i), 32'h60 + 32'(i));
    join
  endtask
  task automatic t_irq;
    wr(FIFO_CONTROL_ADDR, 32'h0);
    bus(1'b0, IRQ_STATUS_ADDR, 32'h0);
    wr(IRQ_MASK_ADDR, 32'h1);
    i_serial_peer.send(8'h77, 1'b0);
    chk(32'(irq), 32'h1);
    rdc(IRQ_STATUS_ADDR, 32'h1);
    @(negedge ref_clk);
    chk(32'(irq), 32'h0);
    rdc(sh(7), 32'h77);
    wr(IRQ_MASK_ADDR, 32'h0);
    i_serial_peer.send(8'h78, 1'b0);
    chk(32'(irq), 32'h0);
    rdc(sh(8), 32'h78);
  endtask
  task automatic t_ir;
    wr(MODE_CONTROL_ADDR, 32'h1);
    i_serial_peer.send(8'hA5, 1'b1);
    rdc(sh(15), 32'hA5);
    fork
      wr(sh(0), 32'hC3);
      get(1'b1, 8'hC3);
    join
    chk(32'(sout), 32'h1);
  endtask
  // ==========================================================
  // main sequence
  initial
  begin
    err_count = 0;
    checks_done = 0;
    rst_n = 1'b0;
    avs_address = 32'h0;
    avs_writedata = 32'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_byteenable = 4'hF;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_reset;
    t_rx_off;
    t_rx_fifo;
    t_tx_off;
    t_tx_fifo;
    t_irq;
    t_ir;
    report_and_stop;
  end
endmodule
